// file: hdl/sbc_gate.sv
// Per-peripheral disable: reset, clock gate and write block for each peripheral.
// Assumes the peripheral clock enable is sampled by downstream clock gating cells.
`include "sbc_defines.svh"
module sbc_gate #(
    parameter int NUM = 12
) (
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    // Disable bits and peripheral writes
    input  wire logic [NUM-1:0] disableBits,
    input  wire logic [NUM-1:0] perWriteReq,
    // Gated controls
    output logic      [NUM-1:0] perReset_n,
    output logic      [NUM-1:0] perClkEn,
    output logic      [NUM-1:0] perWriteOk
);
    generate
        if (NUM < 1) begin : g_bad_num
            $error("sbc_gate needs at least one peripheral");
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < NUM; gi++) begin : g_per
            logic rst_q;
            // Registered so the peripheral reset is glitch free
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    rst_q <= 1'b0;
                end else begin
                    rst_q <= !disableBits[gi];
                end
            end
            assign perReset_n[gi] = rst_q;
            assign perClkEn[gi]   = !disableBits[gi];
            assign perWriteOk[gi] = perWriteReq[gi] && !disableBits[gi];
        end
    endgenerate

    property p_block_write;
        @(posedge core_clk) disable iff (!reset_n)
        disableBits != '0 |-> (perWriteOk & disableBits) == '0;
    endproperty
    a_block_write: assert property (p_block_write) else $error("write passed to disabled peripheral");

    property p_held_reset;
        @(posedge core_clk) disable iff (!reset_n)
        disableBits[0] [*2] |-> !perReset_n[0] && !perClkEn[0];
    endproperty
    a_held_reset: assert property (p_held_reset) else $error("disabled peripheral not reset");
endmodule

// file: hdl/sbc_standby_ctrl.sv
// Standby-mode controller with stop unlock and timer block gating.
// Assumes a CPU register port with one-cycle strobes and read data one cycle later;
// interrupt enable and request flags arrive from logic on the same clock.
//
// The address-and-strobe port was decided locally.
`include "sbc_defines.svh"
module sbc_standby_ctrl #(
    parameter int NUM_TIMER8 = 8,
    parameter int NUM_MTIMER = 4,
    parameter int NUM_IRQ    = 32
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Register port
    input  wire logic [15:0]           regAddr,
    input  wire logic [15:0]           regWdata,
    input  wire logic [1:0]            regByteEn,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [15:0]           regRdata,
    // Interrupt flags
    input  wire logic [NUM_IRQ-1:0]    irqEnable,
    input  wire logic [NUM_IRQ-1:0]    irqRequest,
    // Core and clock controls
    output logic                       cpuStop,
    output logic                       fastOscStop,
    output logic                       slowOscStop,
    output logic                       periphClkStop,
    output logic                       lowPowerRun,
    output logic [2:0]                 powerMode,
    // Timer gating
    input  wire logic [11:0]           timerWriteReq,
    output logic      [11:0]           timerReset_n,
    output logic      [11:0]           timerClkEn,
    output logic      [11:0]           timerWriteOk
);
    // Refused while elaborating, since the gating register layout fixes the timer counts
    generate
        if (NUM_TIMER8 != 8 || NUM_MTIMER != 4) begin : g_bad_timers
            $error("timer counts fixed by the gating register layout");
        end
        if (NUM_IRQ < 1) begin : g_bad_irq
            $error("need at least one interrupt source");
        end
    endgenerate

    sbc_pkg::sbc_mode_e mode_q;
    logic [11:0]        gate_q;
    logic [3:0]         req_q;
    logic [15:0]        rdata_q;
    logic               armed;
    logic               irqPending;
    logic               stopEntered;
    logic               stdbyWrite;
    logic               codeWrite;
    logic [7:0]         laneData;

    // Byte lane selected by the address low bit, used by the unlock and standby registers
    function automatic logic [7:0] lane_byte(input logic [15:0] addr, input logic [15:0] data);
        lane_byte = addr[0] ? data[15:8] : data[7:0];
    endfunction

    assign laneData    = lane_byte(regAddr, regWdata);
    assign irqPending  = |(irqEnable & irqRequest);
    assign codeWrite   = regWrite && regAddr == `SBC_ADDR_UNLOCK;
    assign stdbyWrite  = regWrite && regAddr == `SBC_ADDR_STANDBY;
    assign stopEntered = req_q[`SBC_BIT_STOP] && mode_q == sbc_pkg::SBC_RUN && !irqPending;

    sbc_unlock u_unlock (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .codeWrite   (codeWrite),
        .codeData    (laneData),
        .irqPending  (irqPending),
        .stopEntered (stopEntered),
        .armed       (armed)
    );

    // Request bits: one-shot triggers, cleared the next cycle in run without a write, whether or not the mode is taken
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= `SBC_REQ_RESET;
        end else if (stdbyWrite) begin
            req_q[`SBC_BIT_HALT]  <= laneData[`SBC_BIT_HALT];
            req_q[`SBC_BIT_STOP]  <= laneData[`SBC_BIT_STOP] && armed;
            req_q[`SBC_BIT_DEEP]  <= laneData[`SBC_BIT_DEEP];
            req_q[`SBC_BIT_HALTH] <= laneData[`SBC_BIT_HALTH];
        end else if (mode_q == sbc_pkg::SBC_RUN) begin
            // A blocked request is dropped so a pending interrupt never leaves it latent
            req_q <= `SBC_REQ_RESET;
        end
    end

    // Mode sequencer; a pending enabled request wakes regardless of global enable
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= sbc_pkg::SBC_RUN;
        end else begin
            case (mode_q)
                sbc_pkg::SBC_RUN: begin
                    if (!irqPending) begin
                        if (req_q[`SBC_BIT_STOP]) begin
                            mode_q <= sbc_pkg::SBC_STOP;
                        end else if (req_q[`SBC_BIT_HALT]) begin
                            mode_q <= sbc_pkg::SBC_HALT;
                        end else if (req_q[`SBC_BIT_DEEP]) begin
                            mode_q <= sbc_pkg::SBC_DEEP;
                        end else if (req_q[`SBC_BIT_HALTH]) begin
                            mode_q <= sbc_pkg::SBC_HALTH;
                        end
                    end
                end
                sbc_pkg::SBC_HALT, sbc_pkg::SBC_HALTH, sbc_pkg::SBC_DEEP, sbc_pkg::SBC_STOP: begin
                    if (irqPending) begin
                        mode_q <= sbc_pkg::SBC_RUN;
                    end
                end
                default: begin
                    mode_q <= sbc_pkg::SBC_RUN;
                end
            endcase
        end
    end

    // Timer disable register, byte or word writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_q <= 12'(`SBC_GATE_RESET);
        end else if (regWrite && regAddr == `SBC_ADDR_GATE_LO) begin
            if (regByteEn[0]) begin
                gate_q[7:0] <= regWdata[7:0];
            end
            if (regByteEn[1]) begin
                gate_q[11:8] <= regWdata[11:8];
            end
        end else if (regWrite && regAddr == `SBC_ADDR_GATE_HI) begin
            gate_q[11:8] <= regWdata[11:8];
        end
    end

    // Read data; write-only registers and unmapped addresses read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                `SBC_ADDR_GATE_LO: rdata_q <= {4'h0, gate_q};
                `SBC_ADDR_GATE_HI: rdata_q <= {4'h0, gate_q[11:8], 8'h00};
                `SBC_ADDR_UNLOCK:  rdata_q <= 16'h0000;
                default:           rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign regRdata = rdata_q;

    sbc_gate #(
        .NUM (12)
    ) u_gate (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .disableBits (gate_q),
        .perWriteReq (timerWriteReq),
        .perReset_n  (timerReset_n),
        .perClkEn    (timerClkEn),
        .perWriteOk  (timerWriteOk)
    );

    // Clock and core controls per mode
    assign cpuStop       = mode_q != sbc_pkg::SBC_RUN;
    assign fastOscStop   = mode_q == sbc_pkg::SBC_STOP || mode_q == sbc_pkg::SBC_HALTH
                           || mode_q == sbc_pkg::SBC_DEEP;
    assign slowOscStop   = mode_q == sbc_pkg::SBC_STOP;
    assign periphClkStop = mode_q == sbc_pkg::SBC_STOP || mode_q == sbc_pkg::SBC_DEEP;
    assign lowPowerRun   = mode_q == sbc_pkg::SBC_DEEP;
    assign powerMode     = 3'(mode_q);

    property p_stop_needs_arm;
        @(posedge core_clk) disable iff (!reset_n)
        stdbyWrite && laneData[`SBC_BIT_STOP] && !armed |=> !req_q[`SBC_BIT_STOP];
    endproperty
    a_stop_needs_arm: assert property (p_stop_needs_arm) else $error("stop accepted while disarmed");

    property p_halt_entry;
        @(posedge core_clk) disable iff (!reset_n)
        stdbyWrite && laneData == 8'h01 && mode_q == sbc_pkg::SBC_RUN ##1 !irqPending
        |=> mode_q == sbc_pkg::SBC_HALT;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");

    property p_no_entry_irq;
        @(posedge core_clk) disable iff (!reset_n)
        mode_q == sbc_pkg::SBC_RUN && irqPending |=> mode_q == sbc_pkg::SBC_RUN;
    endproperty
    a_no_entry_irq: assert property (p_no_entry_irq) else $error("sleep entered with interrupt pending");

    property p_wake;
        @(posedge core_clk) disable iff (!reset_n)
        mode_q != sbc_pkg::SBC_RUN && irqPending |=> mode_q == sbc_pkg::SBC_RUN && !cpuStop;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on pending interrupt");

    property p_oneshot;
        @(posedge core_clk) disable iff (!reset_n)
        mode_q == sbc_pkg::SBC_RUN && !stdbyWrite |=> req_q == 4'h0;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("request bit did not clear");

    property p_unlock_read;
        @(posedge core_clk) disable iff (!reset_n)
        regRead && regAddr == `SBC_ADDR_UNLOCK |=> regRdata == 16'h0000;
    endproperty
    a_unlock_read: assert property (p_unlock_read) else $error("unlock register read nonzero");

    property p_stop_osc;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(mode_q == sbc_pkg::SBC_STOP) |-> slowOscStop && fastOscStop && $past(armed, 2);
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("stop without oscillators off or unlock");

    property p_gate_write;
        @(posedge core_clk) disable iff (!reset_n)
        regWrite && regAddr == `SBC_ADDR_GATE_LO && regByteEn == 2'h3
        |=> {4'h0, gate_q} == ($past(regWdata) & 16'h0FFF);
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("gating word write lost");

    c_stop:  cover property (@(posedge core_clk) disable iff (!reset_n) mode_q == sbc_pkg::SBC_STOP);
    c_deep:  cover property (@(posedge core_clk) disable iff (!reset_n) mode_q == sbc_pkg::SBC_DEEP);
    c_halth: cover property (@(posedge core_clk) disable iff (!reset_n) mode_q == sbc_pkg::SBC_HALTH);
    c_gate:  cover property (@(posedge core_clk) disable iff (!reset_n) gate_q[11] && gate_q[0]);
endmodule

// file: hdl/sbc_unlock.sv
// Two-step unlock acceptor that permits the stop request.
// Assumes writes arrive as single-cycle strobes on the core clock.
`include "sbc_defines.svh"
module sbc_unlock (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Code writes
    input  wire logic       codeWrite,
    input  wire logic [7:0] codeData,
    // Conditions
    input  wire logic       irqPending,
    input  wire logic       stopEntered,
    // Result
    output logic            armed
);
    logic firstSeen_q;
    logic armed_q;

    // First code flag; any code write after it drops it, a repeated first code included
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            firstSeen_q <= 1'b0;
        end else if (stopEntered) begin
            firstSeen_q <= 1'b0;
        end else if (codeWrite) begin
            // Only further code writes matter, so unrelated bus traffic leaves it
            firstSeen_q <= (codeData[7:4] == `SBC_CODE_FIRST) && !firstSeen_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else if (stopEntered) begin
            armed_q <= 1'b0;
        end else if (codeWrite && firstSeen_q && codeData[7:4] == `SBC_CODE_SECOND && !irqPending) begin
            armed_q <= 1'b1;
        end
    end

    assign armed = armed_q;

    property p_arm_cause;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(armed_q) |-> $past(codeWrite) && $past(firstSeen_q) && !$past(irqPending);
    endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("unlock armed without valid sequence");

    property p_irq_block;
        @(posedge core_clk) disable iff (!reset_n)
        irqPending && !armed_q |=> !armed_q;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("unlock armed with interrupt pending");

    property p_disarm;
        @(posedge core_clk) disable iff (!reset_n)
        stopEntered |=> !armed_q && !firstSeen_q;
    endproperty
    a_disarm: assert property (p_disarm) else $error("unlock still armed after stop");

    property p_discard;
        @(posedge core_clk) disable iff (!reset_n)
        firstSeen_q && codeWrite && codeData[7:4] != `SBC_CODE_SECOND |=> !firstSeen_q && !$rose(armed_q);
    endproperty
    a_discard: assert property (p_discard) else $error("first code kept after wrong byte");

    c_armed: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(armed_q));
endmodule

// file: inc/sbc_defines.svh
// Constants for the standby-mode and timer block-gating controller.
// Assumes a byte-addressed register port with separate byte lanes for 16-bit words.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
`define SBC_ADDR_UNLOCK      16'hF008
`define SBC_ADDR_STANDBY     16'hF009
`define SBC_ADDR_GATE_LO     16'hF068
`define SBC_ADDR_GATE_HI     16'hF069
`define SBC_BIT_HALT         0
`define SBC_BIT_STOP         1
`define SBC_BIT_DEEP         2
`define SBC_BIT_HALTH        3
`define SBC_CODE_FIRST       4'h5
`define SBC_CODE_SECOND      4'hA
`define SBC_GATE_RESET       16'h0000
`define SBC_REQ_RESET        4'h0
`define SBC_GATE_USED_HI     4'hF
`endif

// file: inc/sbc_pkg.sv
// Types shared by the standby controller files.
// Assumes the constants header is included where numbers are needed.
package sbc_pkg;
    typedef enum logic [2:0] {
        SBC_RUN,
        SBC_HALT,
        SBC_HALTH,
        SBC_DEEP,
        SBC_STOP
    } sbc_mode_e;
endpackage

// file: verif/tb_sbc_standby_ctrl.sv
// Self-checking bench for the standby controller: register tasks, mode entry and timer gating.
// Assumes the controller takes one-cycle strobes, answers reads a cycle later and enters modes within a few cycles.
`include "sbc_defines.svh"
module tb_sbc_standby_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk;
    logic        reset_n;
    logic [15:0] regAddr;
    logic [15:0] regWdata;
    logic [1:0]  regByteEn;
    logic        regWrite;
    logic        regRead;
    logic [15:0] regRdata;
    logic [31:0] irqEnable;
    logic [31:0] irqRequest;
    logic        cpuStop;
    logic        fastOscStop;
    logic        slowOscStop;
    logic        periphClkStop;
    logic        lowPowerRun;
    logic [2:0]  powerMode;
    logic [11:0] timerWriteReq;
    logic [11:0] timerReset_n;
    logic [11:0] timerClkEn;
    logic [11:0] timerWriteOk;
    logic [15:0] rdVal;
    int          failures;
    int          samplesChecked;
    // Requests that need no unlock, their modes and {cpu, fast, slow, periph, lowpower} stops
    logic [15:0] reqBits [3] = '{16'h0001, 16'h0004, 16'h0008};
    logic [2:0]  reqMode [3] = '{sbc_pkg::SBC_HALT, sbc_pkg::SBC_DEEP, sbc_pkg::SBC_HALTH};
    logic [4:0]  reqFlag [3] = '{5'b10000, 5'b11011, 5'b11000};

    sbc_standby_ctrl DUT (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .regAddr       (regAddr),
        .regWdata      (regWdata),
        .regByteEn     (regByteEn),
        .regWrite      (regWrite),
        .regRead       (regRead),
        .regRdata      (regRdata),
        .irqEnable     (irqEnable),
        .irqRequest    (irqRequest),
        .cpuStop       (cpuStop),
        .fastOscStop   (fastOscStop),
        .slowOscStop   (slowOscStop),
        .periphClkStop (periphClkStop),
        .lowPowerRun   (lowPowerRun),
        .powerMode     (powerMode),
        .timerWriteReq (timerWriteReq),
        .timerReset_n  (timerReset_n),
        .timerClkEn    (timerClkEn),
        .timerWriteOk  (timerWriteOk)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_mode(input logic [2:0] m, input logic [4:0] f);
        samplesChecked++;
        if (powerMode !== m || {cpuStop, fastOscStop, slowOscStop, periphClkStop, lowPowerRun} !== f) begin
            failures++;
            $display("[ERR] %0t mode %h stops %b expected %h %b", $time, powerMode,
                     {cpuStop, fastOscStop, slowOscStop, periphClkStop, lowPowerRun}, m, f);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge core_clk);
        regAddr   <= a;
        regWdata  <= d;
        regByteEn <= be;
        regWrite  <= 1'b1;
        @(posedge core_clk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
    endtask

    // A refusal can only be seen after the full entry latency has passed, hence the settle option
    task automatic mode_is(input logic [2:0] m, input logic [4:0] f, input bit settle);
        int n;
        if (settle) begin
            repeat (6) @(negedge core_clk);
        end
        n = 0;
        while (powerMode !== m && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 8) begin
            failures++;
            $display("[ERR] %0t mode %h not reached", $time, m);
            end_sim();
        end else begin
            chk_mode(m, f);
        end
    endtask

    // An enabled pending request wakes the core even though nothing here models global masking
    task automatic wake(input int src);
        @(posedge core_clk);
        irqEnable[src]  <= 1'b1;
        irqRequest[src] <= 1'b1;
        repeat (2) @(posedge core_clk);
        irqEnable  <= '0;
        irqRequest <= '0;
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b0);
    endtask

    initial begin
        #500us;
        failures++;
        end_sim();
    end

    initial begin
        failures       = 0;
        samplesChecked = 0;
        reset_n        = 1'b0;
        regAddr        = '0;
        regWdata       = '0;
        regByteEn      = '0;
        regWrite       = 1'b0;
        regRead        = 1'b0;
        irqEnable      = '0;
        irqRequest     = '0;
        timerWriteReq  = 12'hFFF;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`SBC_ADDR_GATE_LO, rdVal);
        chk_data(rdVal, 16'h0000, "gate reset");
        chk_data({4'h0, timerClkEn}, 16'h0FFF, "clock enables after reset");
        chk_data({4'h0, timerWriteOk}, 16'h0FFF, "writes pass after reset");
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b0);
        wr(`SBC_ADDR_UNLOCK, 16'h005F, 2'b01);
        rd(`SBC_ADDR_UNLOCK, rdVal);
        chk_data(rdVal, 16'h0000, "unlock register reads zero");
        wr(`SBC_ADDR_UNLOCK, 16'h003C, 2'b01);
        wr(`SBC_ADDR_UNLOCK, 16'h00A0, 2'b01);
        wr(`SBC_ADDR_STANDBY, 16'h0200, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        wr(`SBC_ADDR_UNLOCK, 16'h0050, 2'b01);
        wr(`SBC_ADDR_UNLOCK, 16'h0051, 2'b01);
        wr(`SBC_ADDR_UNLOCK, 16'h00A2, 2'b01);
        wr(`SBC_ADDR_STANDBY, 16'h0200, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        wr(`SBC_ADDR_UNLOCK, 16'h0053, 2'b01);
        wr(`SBC_ADDR_GATE_LO, 16'h0000, 2'b11);
        rd(`SBC_ADDR_GATE_LO, rdVal);
        wr(`SBC_ADDR_UNLOCK, 16'h00A7, 2'b01);
        wr(`SBC_ADDR_STANDBY, 16'h0200, 2'b10);
        mode_is(sbc_pkg::SBC_STOP, 5'b11110, 1'b0);
        wake(5);
        wr(`SBC_ADDR_STANDBY, 16'h0200, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        @(posedge core_clk);
        irqEnable[31]  <= 1'b1;
        irqRequest[31] <= 1'b1;
        wr(`SBC_ADDR_UNLOCK, 16'h0050, 2'b01);
        wr(`SBC_ADDR_UNLOCK, 16'h00A0, 2'b01);
        wr(`SBC_ADDR_STANDBY, 16'h0100, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        @(posedge core_clk);
        irqEnable  <= '0;
        irqRequest <= '0;
        wr(`SBC_ADDR_STANDBY, 16'h0200, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        wr(`SBC_ADDR_STANDBY, 16'h0000, 2'b10);
        mode_is(sbc_pkg::SBC_RUN, 5'b00000, 1'b1);
        for (int i = 0; i < 3; i++) begin
            // One request bit per write; oscillator status lives outside this block and is taken as settled
            wr(`SBC_ADDR_STANDBY, reqBits[i] << 8, 2'b10);
            mode_is(reqMode[i], reqFlag[i], 1'b0);
            wake(i);
        end
        wr(`SBC_ADDR_GATE_LO, 16'hFA5C, 2'b11);
        rd(`SBC_ADDR_GATE_LO, rdVal);
        chk_data(rdVal, 16'h0A5C, "gate word");
        rd(`SBC_ADDR_GATE_HI, rdVal);
        chk_data(rdVal, 16'h0A00, "gate high byte");
        chk_data({4'h0, timerClkEn}, 16'h05A3, "clock enables");
        chk_data({4'h0, timerReset_n}, 16'h05A3, "timer resets");
        chk_data({4'h0, timerWriteOk}, 16'h05A3, "timer writes");
        wr(`SBC_ADDR_GATE_LO, 16'h0F03, 2'b01);
        wr(`SBC_ADDR_GATE_HI, 16'h0500, 2'b10);
        rd(`SBC_ADDR_GATE_LO, rdVal);
        chk_data(rdVal, 16'h0503, "gate byte writes");
        wr(`SBC_ADDR_GATE_LO, 16'h0000, 2'b11);
        rd(16'h1234, rdVal);
        chk_data(rdVal, 16'h0000, "unmapped read");
        chk_data({4'h0, timerReset_n}, 16'h0FFF, "resets released");
        chk_data({4'h0, timerWriteOk}, 16'h0FFF, "writes restored");
        end_sim();
    end
endmodule
